// ===== hdl/mct_cfg.svh
`ifndef MCT_CFG_SVH
`define MCT_CFG_SVH

// Register offsets
`define MCT_OFS_TRIG     8'h00
`define MCT_OFS_CTRL     8'h08
`define MCT_OFS_RB       8'h1c
`define MCT_OFS_CA       8'h32
`define MCT_OFS_CB       8'h46

// Control word fields
`define MCT_F_MODE       2:0
`define MCT_F_POL        3
`define MCT_F_ALVL       5:4
`define MCT_F_BCFG       7:6
`define MCT_F_CCFG       9:8
`define MCT_F_CSRC       12:10
`define MCT_F_DEB        13
`define MCT_F_IRQ        15

// Field codes
`define MCT_M_QUAD       3'h1
`define MCT_M_PWM        3'h2
`define MCT_M_WDOG       3'h3
`define MCT_M_EVFREQ     3'h4
`define MCT_M_PULSE      3'h5
`define MCT_M_PERIOD     3'h6
`define MCT_M_ONESHOT    3'h7
`define MCT_LVL_LOW      2'h1
`define MCT_LVL_HIGH     2'h2
`define MCT_BCFG_EXTCLK  2'h1
`define MCT_CSRC_EXT     3'h5
`define MCT_CSRC_FREQ    3'h7

// Reset values
`define MCT_RST_CTRL     16'h0000
`define MCT_RST_OUT      1'b1

// Timing
`define MCT_CLK_NS       100
`define MCT_PULSE_NS     1750
`define MCT_DEB_NS       2500
`define MCT_PULSE_CYC    ((`MCT_PULSE_NS + `MCT_CLK_NS - 1) / `MCT_CLK_NS)
`define MCT_DEB_CYC      ((`MCT_DEB_NS + `MCT_CLK_NS - 1) / `MCT_CLK_NS)

`endif

// ===== hdl/mct_pkg.sv
package mct_pkg;

    typedef enum logic [3:0] {
        MCT_IDLE = 4'b0001,
        MCT_ARM  = 4'b0010,
        MCT_MEAS = 4'b0100,
        MCT_RUN  = 4'b1000
    } mct_fsm_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } mct_req_s;

    typedef struct packed {
        mct_fsm_e        fsm;
        logic [2:0]      s1;
        logic [2:0]      s2;
        logic [2:0]      s3;
        logic [2:0]      clean;
        logic [2:0]      filt;
        logic [2:0][4:0] dcnt;
        logic [15:0]     ctrl;
        logic [15:0]     ca;
        logic [15:0]     cb;
        logic [15:0]     cnt;
        logic [15:0]     rb;
        logic [15:0]     rdata;
        logic            phase;
        logic [4:0]      pcnt;
        logic            out;
        logic            irq;
    } mct_st_s;

endpackage

// ===== hdl/mct_top.sv
`timescale 1ns/1ns
`include "mct_cfg.svh"

module mct_top (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    // Register port
    input  wire mct_pkg::mct_req_s i_req,
    output logic [15:0]            o_rdata,
    // Field pins
    input  wire logic              i_field_input_first,
    input  wire logic              i_field_input_second,
    input  wire logic              i_field_input_third,
    output logic                   o_channel_one_output,
    output logic                   o_irq
);
    import mct_pkg::*;

    localparam logic [4:0] PULSE_LD = 5'(`MCT_PULSE_CYC);
    localparam logic [4:0] DEB_LAST = 5'(`MCT_DEB_CYC - 1);
    localparam int         PULSE_M1 = `MCT_PULSE_CYC - 1;

    mct_st_s     st_r;
    mct_st_s     st_nxt;
    logic [2:0]  mode;
    logic [1:0]  alvl;
    logic [1:0]  blvl;
    logic [1:0]  ccfg;
    logic        freq_m;
    logic        ev_m;
    logic        hold_m;
    logic        live_m;
    logic        a_now;
    logic        a_rise;
    logic        a_fall;
    logic        b_rise;
    logic        c_now;
    logic        c_rise;
    logic        tick;
    logic        gate;
    logic        trig;
    logic        fire;
    logic        act;

    function automatic logic f_act(input logic x, input logic [1:0] lvl);
        f_act = (lvl == `MCT_LVL_LOW) ? ~x : ((lvl == `MCT_LVL_HIGH) ? x : 1'b0);
    endfunction

    assign mode   = st_r.ctrl[`MCT_F_MODE];
    assign alvl   = st_r.ctrl[`MCT_F_ALVL];
    assign ccfg   = st_r.ctrl[`MCT_F_CCFG];
    // A clock on the second input counts its rising edge
    assign blvl   = (st_r.ctrl[`MCT_F_BCFG] == `MCT_BCFG_EXTCLK) ? `MCT_LVL_HIGH
                                                                 : st_r.ctrl[`MCT_F_BCFG];
    assign freq_m = (mode == `MCT_M_EVFREQ) && (st_r.ctrl[`MCT_F_CSRC] == `MCT_CSRC_FREQ);
    assign ev_m   = (mode == `MCT_M_EVFREQ) && !freq_m;
    assign hold_m = ev_m || (mode == `MCT_M_ONESHOT) || (mode == `MCT_M_PWM);
    assign live_m = ev_m || (mode == `MCT_M_WDOG) || (mode == `MCT_M_QUAD);

    assign o_rdata              = st_r.rdata;
    assign o_channel_one_output = st_r.out;
    assign o_irq                = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt     = st_r;
        st_nxt.irq = 1'b0;
        fire       = 1'b0;
        // Three-stage sampling; a level counts once stages two and three agree
        st_nxt.s1 = {i_field_input_third, i_field_input_second, i_field_input_first};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.clean[i] = st_r.s3[i];
            end
            if (st_r.ctrl[`MCT_F_DEB] && (i != 1)) begin
                // Level must hold for the debounce time before it is taken
                if (st_nxt.clean[i] != st_r.filt[i]) begin
                    if (st_r.dcnt[i] == DEB_LAST) begin
                        st_nxt.filt[i] = st_nxt.clean[i];
                        st_nxt.dcnt[i] = 5'h00;
                    end else begin
                        st_nxt.dcnt[i] = st_r.dcnt[i] + 5'h01;
                    end
                end else begin
                    st_nxt.dcnt[i] = 5'h00;
                end
            end else begin
                st_nxt.filt[i] = st_nxt.clean[i];
                st_nxt.dcnt[i] = 5'h00;
            end
        end

        a_now  = f_act(st_nxt.filt[0], alvl);
        a_rise = a_now && !f_act(st_r.filt[0], alvl);
        a_fall = !a_now && f_act(st_r.filt[0], alvl);
        b_rise = f_act(st_nxt.filt[1], blvl) && !f_act(st_r.filt[1], blvl);
        c_now  = f_act(st_nxt.filt[2], ccfg);
        c_rise = c_now && !f_act(st_r.filt[2], ccfg);
        tick   = 1'b1;
        if ((st_r.ctrl[`MCT_F_CSRC] == `MCT_CSRC_EXT) &&
            (st_r.ctrl[`MCT_F_BCFG] == `MCT_BCFG_EXTCLK)) begin
            tick = b_rise;
        end
        gate = hold_m && a_now;
        trig = (i_req.wr && (i_req.addr == `MCT_OFS_TRIG)) ||
               (c_rise && (mode != `MCT_M_QUAD));

        if (st_r.pcnt != 5'h00) begin
            st_nxt.pcnt = st_r.pcnt - 5'h01;
        end

        unique case (st_r.fsm)
            MCT_IDLE: begin
                if (trig) begin
                    st_nxt.cnt   = 16'h0000;
                    st_nxt.phase = 1'b0;
                    if ((mode == `MCT_M_PERIOD) || (mode == `MCT_M_PULSE) || freq_m) begin
                        st_nxt.fsm = MCT_ARM;
                    end else if ((mode == `MCT_M_ONESHOT) || (mode == `MCT_M_PWM) ||
                                 (mode == `MCT_M_WDOG)) begin
                        st_nxt.fsm = MCT_RUN;
                        st_nxt.cnt = st_r.ca;
                    end else if (ev_m || (mode == `MCT_M_QUAD)) begin
                        st_nxt.fsm = MCT_RUN;
                    end
                end
            end
            MCT_ARM: begin
                if (a_rise) begin
                    st_nxt.fsm = MCT_MEAS;
                    st_nxt.cnt = 16'h0000;
                end
            end
            MCT_MEAS: begin
                if (freq_m) begin
                    if (b_rise) begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                    fire = a_fall;
                end else begin
                    // Inputs and clock are unrelated, so one clock of error remains
                    if (tick) begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                    fire = (mode == `MCT_M_PERIOD) ? a_rise : a_fall;
                end
                if (fire) begin
                    st_nxt.rb  = st_r.cnt;
                    st_nxt.fsm = MCT_IDLE;
                end
            end
            MCT_RUN: begin
                if (ev_m) begin
                    if (!gate && b_rise) begin
                        if (st_r.cnt + 16'h0001 == st_r.ca) begin
                            st_nxt.cnt = 16'h0000;
                            fire       = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 16'h0001;
                        end
                    end
                end else if (mode == `MCT_M_WDOG) begin
                    if (a_rise) begin
                        st_nxt.cnt = st_r.ca;
                    end else if (st_r.cnt == 16'h0000) begin
                        st_nxt.fsm = MCT_IDLE;
                        st_nxt.irq = 1'b1;
                    end else if (tick) begin
                        st_nxt.cnt = st_r.cnt - 16'h0001;
                    end
                end else if (mode == `MCT_M_QUAD) begin
                    if (c_rise) begin
                        st_nxt.cnt = st_r.cb;
                        st_nxt.irq = 1'b1;
                    end else if (st_nxt.filt[1:0] != st_r.filt[1:0]) begin
                        // Four counts per cycle; direction from new A against old B
                        if (st_nxt.filt[0] ^ st_r.filt[1]) begin
                            st_nxt.cnt = st_r.cnt + 16'h0001;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                        st_nxt.irq = (st_nxt.cnt == st_r.ca);
                    end
                end else if ((mode == `MCT_M_ONESHOT) || (mode == `MCT_M_PWM)) begin
                    if (!gate && tick) begin
                        if (st_r.cnt <= 16'h0001) begin
                            st_nxt.irq = 1'b1;
                            if (!st_r.phase) begin
                                st_nxt.phase = 1'b1;
                                st_nxt.cnt   = st_r.cb;
                            end else if (mode == `MCT_M_PWM) begin
                                st_nxt.phase = 1'b0;
                                st_nxt.cnt   = st_r.ca;
                            end else begin
                                st_nxt.phase = 1'b0;
                                st_nxt.fsm   = MCT_IDLE;
                            end
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                    end
                end else begin
                    st_nxt.fsm = MCT_IDLE;
                end
            end
            default: begin
                st_nxt.fsm = MCT_IDLE;
            end
        endcase

        if (fire) begin
            st_nxt.pcnt = PULSE_LD;
            st_nxt.irq  = 1'b1;
        end
        if (live_m) begin
            st_nxt.rb = st_nxt.cnt;
        end
        st_nxt.irq = st_nxt.irq && st_r.ctrl[`MCT_F_IRQ];

        if (i_req.wr) begin
            case (i_req.addr)
                `MCT_OFS_CTRL: begin
                    // A new control word stops the channel until the next trigger
                    st_nxt.ctrl  = i_req.wdata;
                    st_nxt.fsm   = MCT_IDLE;
                    st_nxt.phase = 1'b0;
                end
                `MCT_OFS_CA: st_nxt.ca = i_req.wdata;
                `MCT_OFS_CB: st_nxt.cb = i_req.wdata;
                default: ;
            endcase
        end
        if (i_req.rd) begin
            case (i_req.addr)
                `MCT_OFS_CTRL: st_nxt.rdata = st_r.ctrl;
                `MCT_OFS_RB:   st_nxt.rdata = st_r.rb;
                `MCT_OFS_CA:   st_nxt.rdata = st_r.ca;
                `MCT_OFS_CB:   st_nxt.rdata = st_r.cb;
                default:       st_nxt.rdata = 16'h0000;
            endcase
        end

        if ((mode == `MCT_M_ONESHOT) || (mode == `MCT_M_PWM)) begin
            act = (st_nxt.fsm == MCT_RUN) && st_nxt.phase;
        end else if (mode == `MCT_M_WDOG) begin
            act = (st_nxt.fsm == MCT_RUN);
        end else if (mode == `MCT_M_QUAD) begin
            act = (st_nxt.fsm == MCT_RUN) && (c_now || (st_nxt.cnt == st_r.ca));
        end else begin
            act = (st_nxt.pcnt != 5'h00);
        end
        st_nxt.out = st_r.ctrl[`MCT_F_POL] ? act : !act;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r      <= '0;
            st_r.fsm  <= MCT_IDLE;
            st_r.ctrl <= `MCT_RST_CTRL;
            st_r.out  <= `MCT_RST_OUT;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb_ref @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_start_os;
        (st_r.fsm == MCT_IDLE) && trig && (mode == `MCT_M_ONESHOT) &&
        !(i_req.wr && (i_req.addr != `MCT_OFS_TRIG));
    endsequence

    sequence s_period_end;
        (st_r.fsm == MCT_MEAS) && (mode == `MCT_M_PERIOD) && a_rise && !i_req.wr;
    endsequence

    property p_period_arm;
        ((st_r.fsm == MCT_IDLE) && trig && (mode == `MCT_M_PERIOD) && !i_req.wr)
            |=> (st_r.fsm == MCT_ARM);
    endproperty
    a_period_arm: assert property (p_period_arm) else $error("period mode did not arm");

    property p_oneshot_start;
        s_start_os |=> (st_r.fsm == MCT_RUN) && (st_r.cnt == $past(st_r.ca)) && !st_r.phase;
    endproperty
    a_oneshot_start: assert property (p_oneshot_start) else $error("one-shot bad start");

    property p_polarity;
        ((st_r.fsm == MCT_IDLE) && (st_r.pcnt == 5'h00) && $stable(st_r.ctrl) &&
         (mode != `MCT_M_QUAD)) |-> (st_r.out == !st_r.ctrl[`MCT_F_POL]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("idle output not inactive");

    property p_no_debounce;
        (!st_r.ctrl[`MCT_F_DEB] && !i_req.wr) |=> (st_r.filt == st_r.clean);
    endproperty
    a_no_debounce: assert property (p_no_debounce) else $error("filter active");

    property p_period_result;
        s_period_end |=> (st_r.rb == $past(st_r.cnt)) && (st_r.fsm == MCT_IDLE) &&
                         (st_r.pcnt == PULSE_LD);
    endproperty
    a_period_result: assert property (p_period_result) else $error("period result");

    property p_pulse_len;
        ((st_r.pcnt == PULSE_LD) && !ev_m && !i_req.wr)
            |-> ##PULSE_M1 (st_r.pcnt == 5'h01) ##1 (st_r.pcnt == 5'h00);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("done pulse length");

    property p_gate_hold;
        ((st_r.fsm == MCT_RUN) && gate && !i_req.wr)
            |=> $stable(st_r.cnt) && $stable(st_r.phase);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate-off did not hold");

    property p_wdog_end;
        ((st_r.fsm == MCT_RUN) && (mode == `MCT_M_WDOG) && (st_r.cnt == 16'h0000) &&
         !a_rise && !i_req.wr) |=> (st_r.fsm == MCT_IDLE);
    endproperty
    a_wdog_end: assert property (p_wdog_end) else $error("watchdog missed zero");

    property p_event_wrap;
        ((st_r.fsm == MCT_RUN) && ev_m && !gate && b_rise &&
         (st_r.cnt + 16'h0001 == st_r.ca) && !i_req.wr)
            |=> (st_r.cnt == 16'h0000) && (st_r.pcnt == PULSE_LD);
    endproperty
    a_event_wrap: assert property (p_event_wrap) else $error("event limit missed");

    property p_debounce_wait;
        (st_r.ctrl[`MCT_F_DEB] && (st_r.dcnt[0] != DEB_LAST) && !i_req.wr)
            |=> (st_r.filt[0] == $past(st_r.filt[0]));
    endproperty
    a_debounce_wait: assert property (p_debounce_wait) else $error("debounce early");

endmodule

// ===== sim/mct_field_model.sv
`timescale 1ns/1ns

module mct_field_model (
    // Clock
    input  wire logic       i_ref_clk,
    // Commands from the bench
    input  wire logic       i_b_run,
    input  wire logic [7:0] i_b_half,
    input  wire logic       i_a_lvl,
    input  wire logic       i_b_lvl,
    input  wire logic       i_c_lvl,
    // Field lines
    output logic            o_a,
    output logic            o_b,
    output logic            o_c
);
    logic [7:0] half_cnt_r;
    logic       b_clk_r;

    // External count clock stands still while not running
    always_ff @(posedge i_ref_clk) begin
        if (!i_b_run) begin
            half_cnt_r <= 8'h00;
            b_clk_r    <= 1'b0;
        end else if (half_cnt_r + 8'h01 >= i_b_half) begin
            half_cnt_r <= 8'h00;
            b_clk_r    <= ~b_clk_r;
        end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
        end
    end

    assign o_b = i_b_run ? b_clk_r : i_b_lvl;
    assign o_a = i_a_lvl;
    assign o_c = i_c_lvl;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ns
`include "mct_cfg.svh"

module testbench;
    import mct_pkg::*;

    logic        ref_clk;
    logic        rst_b;
    mct_req_s    req;
    logic [15:0] rdata;
    logic        chan_out;
    logic        irq;
    logic        fa;
    logic        fb;
    logic        fc;
    logic        b_run;
    logic [7:0]  b_half;
    logic        a_lvl;
    logic        b_lvl;
    logic        c_lvl;
    logic        act;
    logic [15:0] v;
    logic [15:0] ca;
    logic [15:0] cb;
    int          err_count;
    int          checks;
    int          cyc;
    int          irq_n;
    int          run_n;
    int          last_run;
    int          n;
    int          m;
    int          g;
    int          p;
    int          k;
    int          dly [2];

    mct_top u_dut (
        .i_ref_clk            (ref_clk),
        .i_rst_b              (rst_b),
        .i_req                (req),
        .o_rdata              (rdata),
        .i_field_input_first  (fa),
        .i_field_input_second (fb),
        .i_field_input_third  (fc),
        .o_channel_one_output (chan_out),
        .o_irq                (irq)
    );

    mct_field_model u_field (
        .i_ref_clk (ref_clk),
        .i_b_run   (b_run),
        .i_b_half  (b_half),
        .i_a_lvl   (a_lvl),
        .i_b_lvl   (b_lvl),
        .i_c_lvl   (c_lvl),
        .o_a       (fa),
        .o_b       (fb),
        .o_c       (fc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #50 ref_clk = ~ref_clk;

    // Interrupt count, active run length of the output, hang limit
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_n <= irq_n + 1;
        end
        if (chan_out === act) begin
            run_n <= run_n + 1;
        end else begin
            if (run_n != 0) begin
                last_run <= run_n;
            end
            run_n <= 0;
        end
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [15:0] near(input int a, input int b, input int t);
        return 16'((a - b <= t) && (b - a <= t));
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req = '{1'b1, 1'b0, a, d};
        tick(1);
        req.wr = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a);
        req = '{1'b0, 1'b1, a, 16'h0000};
        tick(1);
        v = rdata;
        req.rd = 1'b0;
        tick(1);
    endtask

    task automatic wait_lvl(input logic l);
        n = 0;
        while (chan_out !== l && n < 200) begin
            tick(1);
            n++;
        end
    endtask

    task automatic bpulse();
        b_lvl = 1'b1;
        tick(3);
        b_lvl = 1'b0;
        tick(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        {b_run, a_lvl, b_lvl, c_lvl} = 4'h0;
        b_half = 8'h02;
        act = 1'b1;
        v = 16'($urandom(32'hdf90f568));
        tick(6);
        chk("out_rst", 16'(chan_out), 16'h0001);
        chk("rdata_rst", rdata, 16'h0000);
        chk("irq_rst", 16'(irq), 16'h0000);
        rst_b = 1'b1;
        tick(20);
        chk("out_idle", 16'(chan_out), 16'h0001);
        rd(`MCT_OFS_CTRL);
        chk("ctrl_rst", v, `MCT_RST_CTRL);
        rd(8'h04);
        chk("unmapped", v, 16'h0000);
        rd(`MCT_OFS_RB);
        ca = v;
        wr(`MCT_OFS_RB, ~ca);
        rd(`MCT_OFS_RB);
        chk("rb_ro", v, ca);
        for (int i = 0; i < 4; i++) begin
            ca = 16'($urandom);
            wr(`MCT_OFS_CA, ca);
            wr(`MCT_OFS_CB, ~ca);
            rd(`MCT_OFS_CA);
            chk("ca_rw", v, ca);
            rd(`MCT_OFS_CB);
            chk("cb_rw", v, ~ca);
        end
        // Period on the external clock, started by the third input
        wr(`MCT_OFS_CTRL, 16'h965e);
        b_half = 8'(2 + $urandom % 3);
        b_run = 1'b1;
        a_lvl = 1'b1;
        tick(10);
        c_lvl = 1'b1;
        tick(6);
        c_lvl = 1'b0;
        tick(6);
        p = 60 + $urandom % 60;
        a_lvl = 1'b0;
        tick(p / 2);
        a_lvl = 1'b1;
        tick(p - p / 2);
        m = irq_n;
        a_lvl = 1'b0;
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        tick(1);
        a_lvl = 1'b1;
        chk("period_pulse", 16'(last_run), 16'(`MCT_PULSE_CYC));
        chk("period_irq", 16'(irq_n - m), 16'h0001);
        rd(`MCT_OFS_RB);
        chk("period_cnt", near(v, p / (2 * b_half), 1), 16'h0001);
        m = irq_n;
        a_lvl = 1'b0;
        tick(p / 2);
        a_lvl = 1'b1;
        tick(p / 2);
        a_lvl = 1'b0;
        tick(40);
        chk("no_retrig", 16'(irq_n - m), 16'h0000);
        b_run = 1'b0;
        // Pulse width without and with input filtering
        for (int d = 0; d < 2; d++) begin
            wr(`MCT_OFS_CTRL, 16'h822d | 16'(d << 13));
            a_lvl = 1'b1;
            tick(40);
            wr(`MCT_OFS_TRIG, 16'h0000);
            a_lvl = 1'b0;
            tick(40);
            p = 30 + $urandom % 50;
            a_lvl = 1'b1;
            tick(p);
            a_lvl = 1'b0;
            wait_lvl(1'b1);
            dly[d] = n;
            rd(`MCT_OFS_RB);
            chk("pulse_cnt", near(v, p, 1), 16'h0001);
        end
        chk("deb_delay", near(dly[1] - dly[0], `MCT_DEB_CYC, 1), 16'h0001);
        // One-shot, some runs paused by gate-off
        for (int i = 0; i < 4; i++) begin
            ca = 16'(3 + $urandom % 15);
            cb = 16'(8 + $urandom % 5);
            g = i[0] ? 2 + $urandom % 5 : 0;
            wr(`MCT_OFS_CA, ca);
            wr(`MCT_OFS_CB, cb);
            wr(`MCT_OFS_CTRL, 16'h822f);
            wr(`MCT_OFS_TRIG, 16'h0000);
            wait_lvl(1'b1);
            chk("os_low", near(n, ca, 2), 16'h0001);
            if (g != 0) begin
                a_lvl = 1'b1;
                tick(g);
                a_lvl = 1'b0;
            end
            wait_lvl(1'b0);
            tick(1);
            chk("os_high", 16'(last_run), cb + 16'(g));
            tick(20);
            chk("os_done", 16'(chan_out), 16'h0000);
        end
        // Watchdog countdown
        ca = 16'(10 + $urandom % 20);
        wr(`MCT_OFS_CA, ca);
        wr(`MCT_OFS_CTRL, 16'h802b);
        m = irq_n;
        wr(`MCT_OFS_TRIG, 16'h0000);
        wait_lvl(1'b0);
        tick(1);
        chk("wd_active", near(last_run, ca, 2), 16'h0001);
        chk("wd_irq", 16'(irq_n - m), 16'h0001);
        // Event counting wraps at the limit
        wr(`MCT_OFS_CA, 16'h0005);
        wr(`MCT_OFS_CTRL, 16'h808c);
        wr(`MCT_OFS_TRIG, 16'h0000);
        m = irq_n;
        repeat (12) bpulse();
        tick(20);
        chk("ev_irq", 16'(irq_n - m), 16'h0002);
        chk("ev_pulse", 16'(last_run), 16'(`MCT_PULSE_CYC));
        rd(`MCT_OFS_RB);
        chk("ev_cnt", v, 16'h0002);
        // Frequency over an enable window
        wr(`MCT_OFS_CTRL, 16'h9cac);
        wr(`MCT_OFS_TRIG, 16'h0000);
        m = irq_n;
        k = 2 + $urandom % 6;
        a_lvl = 1'b1;
        tick(8);
        repeat (k) bpulse();
        tick(8);
        a_lvl = 1'b0;
        wait_lvl(1'b1);
        tick(2);
        chk("fq_irq", 16'(irq_n - m), 16'h0001);
        rd(`MCT_OFS_RB);
        chk("fq_cnt", v, 16'(k));
        // Quadrature: index reload, then one full phase cycle onto the limit
        wr(`MCT_OFS_CA, 16'h0104);
        wr(`MCT_OFS_CB, 16'h0100);
        wr(`MCT_OFS_CTRL, 16'h8209);
        wr(`MCT_OFS_TRIG, 16'h0000);
        m = irq_n;
        c_lvl = 1'b1;
        tick(6);
        c_lvl = 1'b0;
        tick(6);
        rd(`MCT_OFS_RB);
        chk("qd_index", v, 16'h0100);
        chk("qd_irq", 16'(irq_n - m), 16'h0001);
        for (int s = 1; s <= 4; s++) begin
            a_lvl = s inside {1, 2};
            b_lvl = s inside {2, 3};
            tick(6);
        end
        rd(`MCT_OFS_RB);
        chk("qd_step", v > 16'h0100 ? v - 16'h0100 : 16'h0100 - v, 16'h0004);
        chk("qd_lim_irq", 16'(irq_n - m), 16'h0002);
        chk("qd_out", 16'(chan_out), 16'h0001);
        end_of_test();
    end
endmodule
